// File: dv/hsmc_far_model.sv
// far side of the mode controller: load charge seen through in_limit, comparator levels,
// enable source and the fault pin pull-up; bench requests change just after a rising hclk edge
`timescale 1ns/1ps
module hsmc_far_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        gate_drive_up,
  input  wire logic        fault_out_n_o,
  input  wire logic        fault_out_n_oe,
  input  wire logic [15:0] charge_cyc,
  input  wire logic        en_req,
  input  wire logic        oc_req,
  input  wire logic        ft_req,
  input  wire logic        short_req,
  input  wire logic        ot_req,
  output logic             switch_enable,
  output logic             over_current,
  output logic             fast_trip,
  output logic             in_limit,
  output logic             current_monitor_over_short,
  output logic             over_temp,
  output logic             fault_out_n_i
);
  logic [15:0] chg_r;

  // released pin floats up through the board resistor
  assign fault_out_n_i = fault_out_n_oe ? fault_out_n_o : 1'b1;
  // limiting only while the gate is up and the output is still charging
  assign in_limit = gate_drive_up && (chg_r < charge_cyc);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg_r                      <= 16'h0000;
      switch_enable              <= 1'b0;
      over_current               <= 1'b0;
      fast_trip                  <= 1'b0;
      current_monitor_over_short <= 1'b0;
      over_temp                  <= 1'b0;
    end else begin
      // output capacitor drains whenever the gate is down, so each start limits again
      chg_r                      <= !gate_drive_up ? 16'h0000 : (in_limit ? chg_r + 16'h0001 : chg_r);
      switch_enable              <= en_req;
      over_current               <= oc_req;
      fast_trip                  <= ft_req;
      current_monitor_over_short <= short_req;
      over_temp                  <= ot_req;
    end
  end
endmodule // hsmc_far_model

// File: dv/tb.sv
// bench: register-port master, expected modes per response option, watchdog
// assumes hsmc_pkg, hsmc_top and hsmc_far_model are compiled first
`timescale 1ns/1ps
module tb;
  localparam logic [23:0] ITC_DEF = 24'h00_000a;
  localparam logic [23:0] FTC_DEF = 24'h00_0014;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, uvl, irq, en_req, oc_req, ft_req, short_req, ot_req;
  logic        sw_en, oc, ft, lim, shrt, ot, gate_up, gate_dn, pd, flt_o, flt_oe, flt_i;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [15:0] charge;
  logic [2:0]  hsize;
  logic [1:0]  htrans, opt;
  int          error_cnt, checks, itc, c;

  hsmc_top #(.INRUSH_TC_DEF(ITC_DEF), .FAULT_TC_DEF(FTC_DEF)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .undervoltage_lockout(uvl), .switch_enable(sw_en), .over_current(oc), .fast_trip(ft), .in_limit(lim),
    .current_monitor_over_short(shrt), .over_temp(ot), .response_option(opt), .gate_drive_up(gate_up),
    .gate_drive_down(gate_dn), .gate_strong_pd(pd), .fault_out_n_o(flt_o), .fault_out_n_oe(flt_oe),
    .fault_out_n_i(flt_i), .irq(irq));

  hsmc_far_model i_far (
    .hclk(hclk), .hresetn(hresetn), .gate_drive_up(gate_up), .fault_out_n_o(flt_o), .fault_out_n_oe(flt_oe),
    .charge_cyc(charge), .en_req(en_req), .oc_req(oc_req), .ft_req(ft_req), .short_req(short_req),
    .ot_req(ot_req), .switch_enable(sw_en), .over_current(oc), .fast_trip(ft), .in_limit(lim),
    .current_monitor_over_short(shrt), .over_temp(ot), .fault_out_n_i(flt_i));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    chk("hreadyout", 32'(hreadyout), 32'h0000_0001);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0000_0000);
  endtask

  // model: landing mode after a timeout (to=1) or a fast trip (to=0) for option o
  function automatic logic [2:0] land(input bit to, input int o);
    if (to) return (o == 1) ? hsmc_pkg::MODE_RETRY : hsmc_pkg::MODE_LATCHED;
    return (o == 2) ? hsmc_pkg::MODE_LATCHED : hsmc_pkg::MODE_INRUSH;
  endfunction

  // polls the status register; c returns the cycles spent
  task automatic wait_mode(input logic [2:0] m, input int lim_cyc);
    c = 0;
    do begin
      bus(1'b0, hsmc_pkg::OFS_STATUS, 32'h0000_0000, d);
      c += 3;
    end while (d[2:0] !== m && c < lim_cyc);
    chk("mode", 32'(d[2:0]), 32'(m));
  endtask

  initial begin
    repeat (90000) @(posedge hclk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, uvl, en_req, oc_req, ft_req, short_req, ot_req} = '0;
    {haddr, hwdata, htrans, opt, charge} = '0;
    hsize = 3'b010;
    {error_cnt, checks} = '0;
    void'($urandom(32'h704d));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, hsmc_pkg::OFS_INRUSH_TC, 32'h0000_0000, d);
    chk("itc_rst", d, 32'(ITC_DEF));
    bus(1'b0, hsmc_pkg::OFS_FAULT_TC, 32'h0000_0000, d);
    chk("ftc_rst", d, 32'(FTC_DEF));
    bus(1'b0, hsmc_pkg::OFS_IRQ_MASK, 32'h0000_0000, d);
    chk("mask_rst", d, 32'(hsmc_pkg::IRQ_MASK_RST));
    bus(1'b0, 8'h14, 32'h0000_0000, d);
    chk("unmapped", d, 32'h0000_0000);
    // the last pass straps the unused option code, which must behave as latch
    for (int o = 0; o < 4; o++) begin
      @(posedge hclk);
      hresetn <= 1'b0;
      opt     <= 2'(o);
      en_req  <= 1'b0;
      charge  <= 16'(30 + $urandom % 30);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      itc = 100 + int'($urandom % 50);
      bus(1'b1, hsmc_pkg::OFS_INRUSH_TC, 32'(itc), d);
      bus(1'b0, hsmc_pkg::OFS_INRUSH_TC, 32'h0000_0000, d);
      chk("itc_rw", d, 32'(itc));
      bus(1'b1, hsmc_pkg::OFS_IRQ_MASK, 32'h0000_0002, d);
      @(posedge hclk);
      en_req <= 1'b1;
      wait_mode(hsmc_pkg::MODE_INRUSH, 30);
      wait_mode(hsmc_pkg::MODE_REGULAR, 200);
      chk("opt", 32'(d[6:5]), 32'(o % 3));
      chk("gate_reg", 32'(d[7]), 32'h0000_0001);
      @(posedge hclk);
      oc_req <= 1'b1;
      wait_mode(hsmc_pkg::MODE_FAULT, 30);
      @(posedge hclk);
      oc_req <= 1'b0;
      wait_mode(hsmc_pkg::MODE_REGULAR, 30);
      @(posedge hclk);
      oc_req <= 1'b1;
      wait_mode(hsmc_pkg::MODE_FAULT, 30);
      wait_mode(land(1'b1, o), 60);
      chk("fto_len", 32'(c >= 15), 32'h0000_0001);
      chk("flt_pin", 32'(d[4]), 32'h0000_0000);
      @(posedge hclk);
      oc_req <= 1'b0;
      bus(1'b0, hsmc_pkg::OFS_IRQ_STAT, 32'h0000_0000, d);
      chk("irq_fto", 32'(d[hsmc_pkg::IRQ_FAULT_TO]), 32'h0000_0001);
      if (o == 1) begin
        wait_mode(hsmc_pkg::MODE_INRUSH, 128 * itc + 400);
        chk("retry_len", 32'(c >= 128 * itc - 6), 32'h0000_0001);
      end else begin
        @(posedge hclk);
        en_req <= 1'b0;
        wait_mode(hsmc_pkg::MODE_LATCHED, 9);
        @(posedge hclk);
        en_req <= 1'b1;
        wait_mode(hsmc_pkg::MODE_INRUSH, 20);
      end
      wait_mode(hsmc_pkg::MODE_REGULAR, 200);
      @(posedge hclk);
      ft_req <= 1'b1;
      @(posedge hclk);
      ft_req <= 1'b0;
      c = 0;
      @(negedge hclk);
      while (pd !== 1'b1 && c < 10) begin
        @(negedge hclk);
        c++;
      end
      chk("pd_gate", 32'({gate_up, gate_dn}), 32'h0000_0001);
      c = 0;
      while (pd === 1'b1 && c < 2000) begin
        @(negedge hclk);
        c++;
      end
      chk("pd_len", 32'(c), 32'(hsmc_pkg::FAST_PD_CYC));
      chk("irq_set", 32'(irq), 32'h0000_0001);
      wait_mode(land(1'b0, o), 10);
      bus(1'b0, hsmc_pkg::OFS_IRQ_STAT, 32'h0000_0000, d);
      chk("irq_ft", 32'(d[hsmc_pkg::IRQ_FAST_TRIP]), 32'h0000_0001);
      @(negedge hclk);
      chk("irq_clr", 32'(irq), 32'h0000_0000);
      @(posedge hclk);
      charge <= 16'hffff;
      en_req <= 1'b0;
      repeat (3) @(posedge hclk);
      en_req <= 1'b1;
      wait_mode(hsmc_pkg::MODE_INRUSH, 20);
      wait_mode(land(1'b1, o), itc + 100);
      chk("ito_len", 32'(c >= itc - 6), 32'h0000_0001);
      chk("ito_gate", 32'(d[7]), 32'h0000_0000);
      bus(1'b0, hsmc_pkg::OFS_IRQ_STAT, 32'h0000_0000, d);
      chk("irq_ito", 32'(d[hsmc_pkg::IRQ_INRUSH_TO]), 32'h0000_0001);
    end
    @(posedge hclk);
    ot_req <= 1'b1;
    wait_mode(hsmc_pkg::MODE_OFF, 20);
    chk("ot_pin", 32'(d[4:3]), 32'h0000_0001);
    @(posedge hclk);
    ot_req    <= 1'b0;
    en_req    <= 1'b0;
    short_req <= 1'b1;
    repeat (4) @(negedge hclk);
    chk("short_pin", 32'(flt_i), 32'h0000_0000);
    bus(1'b0, hsmc_pkg::OFS_IRQ_STAT, 32'h0000_0000, d);
    chk("irq_lvl", 32'(d[5:0]), 32'h0000_0030);
    @(posedge hclk);
    short_req <= 1'b0;
    uvl       <= 1'b1;
    en_req    <= 1'b1;
    repeat (4) @(negedge hclk);
    chk("pin_free", 32'(flt_i), 32'h0000_0001);
    wait_mode(hsmc_pkg::MODE_OFF, 10);
    @(posedge hclk);
    uvl <= 1'b0;
    wait_mode(hsmc_pkg::MODE_INRUSH, 20);
    print_verdict();
  end
endmodule // tb

// File: verilog/hsmc_pkg.sv
// constants, field layout and mode codes of the hot-swap mode controller
// assumes a 10 MHz system clock and a 32-bit AHB-Lite register port
package hsmc_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_INRUSH_TC = 8'h00;
  localparam logic [7:0]  OFS_FAULT_TC  = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h10;
  // timer widths and terminal counts after reset (6 ms and 250 ms at 10 MHz)
  localparam int          TMR_W         = 24;
  localparam logic [23:0] INRUSH_TC_RST = 24'h00_ea60;
  localparam logic [23:0] FAULT_TC_RST  = 24'h26_25a0;
  // interrupt status and mask layout
  localparam int          IRQ_W         = 6;
  localparam int          IRQ_INRUSH_TO = 0;
  localparam int          IRQ_FAST_TRIP = 1;
  localparam int          IRQ_FAULT_TO  = 2;
  localparam int          IRQ_LATCHED   = 3;
  localparam int          IRQ_SHORTED   = 4;
  localparam int          IRQ_OVER_TEMP = 5;
  localparam logic [5:0]  IRQ_MASK_RST  = 6'h00;
  // status register layout
  localparam int          STAT_MODE_LSB = 0;
  localparam int          STAT_FAULT    = 3;
  localparam int          STAT_PIN      = 4;
  localparam int          STAT_OPT_LSB  = 5;
  localparam int          STAT_GATE     = 7;
  // retry: full charge and discharge cycles of the inrush timer
  localparam logic [6:0]  RETRY_CYCLES  = 7'h40;
  // strong gate pull-down pulse after a fast trip
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          FAST_PD_NS    = 63000;
  localparam int          PD_W          = 10;
  localparam logic [9:0]  FAST_PD_CYC   = PD_W'(FAST_PD_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    MODE_OFF      = 3'b000,
    MODE_INRUSH   = 3'b001,
    MODE_REGULAR  = 3'b010,
    MODE_FAULT    = 3'b011,
    MODE_LATCHED  = 3'b100,
    MODE_RETRY    = 3'b101
  } hsmc_mode_t;

  typedef enum logic [1:0] {
    OPT_LATCH     = 2'b00,
    OPT_RETRY     = 2'b01,
    OPT_FAST_OFF  = 2'b10
  } hsmc_opt_t;
endpackage

// File: verilog/hsmc_top.sv
// hot-swap mode controller: mode machine, inrush and fault timers, fast-trip pulse,
// fault pin, AHB-Lite register slave with sticky interrupts
// assumes comparator inputs synchronous to hclk; analog gate regulation sits outside
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps

// Contract
// - after reset or lockout release the first operating mode is inrush
// - inrush drives gate except during the fast-trip pull-down; inrush timer advances only while in_limit is high
// - inrush timeout drops gate; latched for latch/fast-off, retry for retry
// - regular mode keeps both timers at zero and gate high
// - overcurrent in regular mode moves to fault mode
// - fast trip in regular mode fires a 63 us strong gate pull-down
// - after fast trip, fast-off latches; latch and retry restart through inrush
// - fault mode advances the fault timer every cycle
// - fault timeout goes latched for latch/fast-off, retry for retry
// - overcurrent clearing before timeout returns fault mode to regular
// - latched mode keeps gate low, timers discharged, fault pin pulled
// - enable rising edge in latched mode clears timers and enters inrush
// - retry runs 64 inrush timer charge/discharge cycles, then inrush
// - fault pin pulls low on timeout, shorted switch, or over-temperature
module hsmc_top #(
  parameter logic [23:0] INRUSH_TC_DEF = hsmc_pkg::INRUSH_TC_RST,
  parameter logic [23:0] FAULT_TC_DEF  = hsmc_pkg::FAULT_TC_RST
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        undervoltage_lockout,
  input  wire logic        switch_enable,
  input  wire logic        over_current,
  input  wire logic        fast_trip,
  input  wire logic        in_limit,
  input  wire logic        current_monitor_over_short,
  input  wire logic        over_temp,
  input  wire logic [1:0]  response_option,
  output logic             gate_drive_up,
  output logic             gate_drive_down,
  output logic             gate_strong_pd,
  output logic             fault_out_n_o,
  output logic             fault_out_n_oe,
  input  wire logic        fault_out_n_i,
  output logic             irq
);
  localparam int W = hsmc_pkg::TMR_W;

  function automatic logic [2:0] reg_index(input logic [31:0] a);
    logic [2:0] idx;
    idx = 3'h7;
    if (a[31:5] == 27'h0 && a[1:0] == 2'b00) begin
      case (a[7:0])
        hsmc_pkg::OFS_INRUSH_TC: idx = 3'h0;
        hsmc_pkg::OFS_FAULT_TC:  idx = 3'h1;
        hsmc_pkg::OFS_STATUS:    idx = 3'h2;
        hsmc_pkg::OFS_IRQ_STAT:  idx = 3'h3;
        hsmc_pkg::OFS_IRQ_MASK:  idx = 3'h4;
        default:                 idx = 3'h7;
      endcase
    end
    return idx;
  endfunction

  hsmc_pkg::hsmc_mode_t mode_r, mode_nxt, timeout_mode;
  hsmc_pkg::hsmc_opt_t  opt_r, opt_nxt;
  logic                 opt_valid_r, opt_valid_nxt, rty_dir_r, rty_dir_nxt, en_q_r, gate_up_nxt, fault_nxt;
  logic                 inrush_to, fault_to, abort, en_rise, acc, dph_wr_r, dph_wr_nxt;
  logic [W-1:0]         inrush_cnt_r, inrush_cnt_nxt, fault_cnt_r, fault_cnt_nxt;
  logic [W-1:0]         inrush_tc_r, inrush_tc_nxt, fault_tc_r, fault_tc_nxt;
  logic [6:0]           rty_num_r, rty_num_nxt;
  logic [9:0]           pd_cnt_r, pd_cnt_nxt;
  logic [5:0]           ev, irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic [2:0]           dph_idx_r, dph_idx_nxt, a_idx;
  logic [31:0]          hrdata_nxt;

  assign inrush_to    = inrush_cnt_r >= inrush_tc_r;
  assign fault_to     = fault_cnt_r >= fault_tc_r;
  assign abort        = undervoltage_lockout | over_temp;
  assign en_rise      = switch_enable & ~en_q_r;
  assign timeout_mode = (opt_r == hsmc_pkg::OPT_RETRY) ? hsmc_pkg::MODE_RETRY : hsmc_pkg::MODE_LATCHED;

  // option capture: the pin is only looked at once, so later strap changes are harmless
  always_comb begin
    opt_valid_nxt = 1'b1;
    opt_nxt       = opt_r;
    if (!opt_valid_r) begin
      case (response_option)
        2'b01:   opt_nxt = hsmc_pkg::OPT_RETRY;
        2'b10:   opt_nxt = hsmc_pkg::OPT_FAST_OFF;
        default: opt_nxt = hsmc_pkg::OPT_LATCH;
      endcase
    end
  end

  // mode machine and timers
  always_comb begin
    mode_nxt       = mode_r;
    inrush_cnt_nxt = inrush_cnt_r;
    fault_cnt_nxt  = fault_cnt_r;
    rty_dir_nxt    = rty_dir_r;
    rty_num_nxt    = rty_num_r;
    pd_cnt_nxt     = (pd_cnt_r != 10'h0) ? pd_cnt_r - 10'h1 : 10'h0;
    ev             = 6'h00;
    case (mode_r)
      hsmc_pkg::MODE_OFF: begin
        inrush_cnt_nxt = '0;
        fault_cnt_nxt  = '0;
        if (switch_enable && opt_valid_r)
          mode_nxt = hsmc_pkg::MODE_INRUSH;
      end
      hsmc_pkg::MODE_INRUSH: begin
        if (inrush_to) begin
          mode_nxt       = timeout_mode;
          inrush_cnt_nxt = '0;
          rty_dir_nxt    = 1'b0;
          rty_num_nxt    = 7'h00;
          ev[hsmc_pkg::IRQ_INRUSH_TO] = 1'b1;
        end else if (in_limit) begin
          inrush_cnt_nxt = inrush_cnt_r + 1'b1;
        end else if (pd_cnt_r == 10'h0) begin
          mode_nxt       = hsmc_pkg::MODE_REGULAR;
          inrush_cnt_nxt = '0;
        end
      end
      hsmc_pkg::MODE_REGULAR: begin
        inrush_cnt_nxt = '0;
        fault_cnt_nxt  = '0;
        if (fast_trip) begin
          pd_cnt_nxt = hsmc_pkg::FAST_PD_CYC;
          ev[hsmc_pkg::IRQ_FAST_TRIP] = 1'b1;
          mode_nxt = (opt_r == hsmc_pkg::OPT_FAST_OFF) ? hsmc_pkg::MODE_LATCHED
                                                       : hsmc_pkg::MODE_INRUSH;
        end else if (over_current) begin
          mode_nxt = hsmc_pkg::MODE_FAULT;
        end
      end
      hsmc_pkg::MODE_FAULT: begin
        if (fault_to) begin
          mode_nxt      = timeout_mode;
          fault_cnt_nxt = '0;
          rty_dir_nxt   = 1'b0;
          rty_num_nxt   = 7'h00;
          ev[hsmc_pkg::IRQ_FAULT_TO] = 1'b1;
        end else if (!over_current) begin
          mode_nxt      = hsmc_pkg::MODE_REGULAR;
          fault_cnt_nxt = '0;
        end else begin
          fault_cnt_nxt = fault_cnt_r + 1'b1;
        end
      end
      hsmc_pkg::MODE_LATCHED: begin
        inrush_cnt_nxt = '0;
        fault_cnt_nxt  = '0;
        if (en_rise)
          mode_nxt = hsmc_pkg::MODE_INRUSH;
      end
      hsmc_pkg::MODE_RETRY: begin
        fault_cnt_nxt = '0;
        if (!rty_dir_r) begin
          inrush_cnt_nxt = inrush_cnt_r + 1'b1;
          if (inrush_cnt_nxt >= inrush_tc_r)
            rty_dir_nxt = 1'b1;
        end else if (inrush_cnt_r != '0) begin
          inrush_cnt_nxt = inrush_cnt_r - 1'b1;
        end else begin
          rty_dir_nxt = 1'b0;
          rty_num_nxt = rty_num_r + 7'h01;
          if (rty_num_nxt == hsmc_pkg::RETRY_CYCLES) begin
            mode_nxt    = hsmc_pkg::MODE_INRUSH;
            rty_num_nxt = 7'h00;
          end
        end
      end
      default: mode_nxt = hsmc_pkg::MODE_OFF;
    endcase
    // lockout and thermal shutdown win over everything; disable does not unlatch
    if (abort || (!switch_enable && mode_r != hsmc_pkg::MODE_LATCHED)) begin
      mode_nxt       = hsmc_pkg::MODE_OFF;
      inrush_cnt_nxt = '0;
      fault_cnt_nxt  = '0;
    end
    ev[hsmc_pkg::IRQ_LATCHED]   = (mode_nxt == hsmc_pkg::MODE_LATCHED) && (mode_r != hsmc_pkg::MODE_LATCHED);
    ev[hsmc_pkg::IRQ_SHORTED]   = ~switch_enable & current_monitor_over_short;
    ev[hsmc_pkg::IRQ_OVER_TEMP] = over_temp;
    gate_up_nxt = (mode_nxt == hsmc_pkg::MODE_INRUSH || mode_nxt == hsmc_pkg::MODE_REGULAR ||
                   mode_nxt == hsmc_pkg::MODE_FAULT) && (pd_cnt_nxt == 10'h0);
    fault_nxt   = (mode_nxt == hsmc_pkg::MODE_LATCHED) || (mode_nxt == hsmc_pkg::MODE_RETRY) ||
                  ev[hsmc_pkg::IRQ_SHORTED] || over_temp;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r          <= hsmc_pkg::MODE_OFF;
      opt_r           <= hsmc_pkg::OPT_LATCH;
      opt_valid_r     <= 1'b0;
      inrush_cnt_r    <= '0;
      fault_cnt_r     <= '0;
      rty_dir_r       <= 1'b0;
      rty_num_r       <= 7'h00;
      pd_cnt_r        <= 10'h0;
      en_q_r          <= 1'b0;
      gate_drive_up   <= 1'b0;
      gate_drive_down <= 1'b1;
      gate_strong_pd  <= 1'b0;
      fault_out_n_o   <= 1'b0;
      fault_out_n_oe  <= 1'b0;
    end else begin
      mode_r          <= mode_nxt;
      opt_r           <= opt_nxt;
      opt_valid_r     <= opt_valid_nxt;
      inrush_cnt_r    <= inrush_cnt_nxt;
      fault_cnt_r     <= fault_cnt_nxt;
      rty_dir_r       <= rty_dir_nxt;
      rty_num_r       <= rty_num_nxt;
      pd_cnt_r        <= pd_cnt_nxt;
      en_q_r          <= switch_enable;
      gate_drive_up   <= gate_up_nxt;
      gate_drive_down <= ~gate_up_nxt;
      gate_strong_pd  <= pd_cnt_nxt != 10'h0;
      fault_out_n_o   <= 1'b0;
      fault_out_n_oe  <= fault_nxt;
    end
  end

  // AHB-Lite slave, zero wait states; read data is registered at the address phase
  assign acc   = hsel & hready & htrans[1];
  assign a_idx = reg_index(haddr);
  always_comb begin
    dph_wr_nxt    = acc & hwrite;
    dph_idx_nxt   = a_idx;
    inrush_tc_nxt = inrush_tc_r;
    fault_tc_nxt  = fault_tc_r;
    irq_mask_nxt  = irq_mask_r;
    irq_stat_nxt  = irq_stat_r;
    hrdata_nxt    = 32'h0000_0000;
    if (dph_wr_r) begin
      case (dph_idx_r)
        3'h0:    inrush_tc_nxt = hwdata[W-1:0];
        3'h1:    fault_tc_nxt  = hwdata[W-1:0];
        3'h4:    irq_mask_nxt  = hwdata[5:0];
        default: ;
      endcase
    end
    if (acc && !hwrite) begin
      case (a_idx)
        3'h0:    hrdata_nxt = {8'h00, inrush_tc_r};
        3'h1:    hrdata_nxt = {8'h00, fault_tc_r};
        3'h2:    hrdata_nxt = {24'h00_0000, gate_drive_up, opt_r, fault_out_n_i, fault_out_n_oe, mode_r};
        3'h3:    hrdata_nxt = {26'h000_0000, irq_stat_r};
        3'h4:    hrdata_nxt = {26'h000_0000, irq_mask_r};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
      if (a_idx == 3'h3)
        irq_stat_nxt = 6'h00;
    end
    // a new event in the clearing cycle survives the read
    irq_stat_nxt = irq_stat_nxt | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_r    <= 1'b0;
      dph_idx_r   <= 3'h7;
      inrush_tc_r <= INRUSH_TC_DEF;
      fault_tc_r  <= FAULT_TC_DEF;
      irq_mask_r  <= hsmc_pkg::IRQ_MASK_RST;
      irq_stat_r  <= 6'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      irq         <= 1'b0;
    end else begin
      dph_wr_r    <= dph_wr_nxt;
      dph_idx_r   <= dph_idx_nxt;
      inrush_tc_r <= inrush_tc_nxt;
      fault_tc_r  <= fault_tc_nxt;
      irq_mask_r  <= irq_mask_nxt;
      irq_stat_r  <= irq_stat_nxt;
      hrdata      <= hrdata_nxt;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      irq         <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  logic [10:0] pd_len_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pd_len_r <= 11'h000;
    else          pd_len_r <= gate_strong_pd ? pd_len_r + 11'h001 : 11'h000;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_start_inrush: assert property ($past(mode_r) == hsmc_pkg::MODE_OFF && mode_r != hsmc_pkg::MODE_OFF
    |-> mode_r == hsmc_pkg::MODE_INRUSH) else $error("left off mode not into inrush");
  chk_inrush_count: assert property (mode_r == hsmc_pkg::MODE_INRUSH && $past(mode_r) == hsmc_pkg::MODE_INRUSH
    |-> inrush_cnt_r == $past(inrush_cnt_r) + ($past(in_limit) ? 24'h00_0001 : 24'h00_0000))
    else $error("inrush timer moved without in_limit");
  chk_inrush_expiry: assert property (mode_r == hsmc_pkg::MODE_INRUSH && inrush_to && !abort && switch_enable
    |=> !gate_drive_up && mode_r == $past(timeout_mode)) else $error("inrush timeout mishandled");
  chk_regular_idle: assert property (mode_r == hsmc_pkg::MODE_REGULAR
    |-> inrush_cnt_r == '0 && fault_cnt_r == '0 && gate_drive_up) else $error("regular mode not idle");
  chk_reg_to_fault: assert property (mode_r == hsmc_pkg::MODE_REGULAR && over_current && !fast_trip &&
    !abort && switch_enable |=> mode_r == hsmc_pkg::MODE_FAULT) else $error("overcurrent ignored");
  chk_fast_pulse: assert property ($fell(gate_strong_pd) |-> pd_len_r == 11'(hsmc_pkg::FAST_PD_CYC))
    else $error("pull-down pulse length wrong");
  chk_fast_next: assert property (mode_r == hsmc_pkg::MODE_REGULAR && fast_trip && !abort && switch_enable
    |=> gate_strong_pd && mode_r == (opt_r == hsmc_pkg::OPT_FAST_OFF ? hsmc_pkg::MODE_LATCHED
    : hsmc_pkg::MODE_INRUSH)) else $error("fast trip response wrong");
  chk_fault_count: assert property (mode_r == hsmc_pkg::MODE_FAULT && $past(mode_r) == hsmc_pkg::MODE_FAULT
    |-> fault_cnt_r == $past(fault_cnt_r) + 24'h00_0001) else $error("fault timer stalled");
  chk_fault_expiry: assert property (mode_r == hsmc_pkg::MODE_FAULT && fault_to && !abort && switch_enable
    |=> mode_r == $past(timeout_mode) && !gate_drive_up) else $error("fault timeout mishandled");
  chk_fault_clear: assert property (mode_r == hsmc_pkg::MODE_FAULT && !over_current && !fault_to && !abort &&
    switch_enable |=> mode_r == hsmc_pkg::MODE_REGULAR) else $error("fault mode did not clear");
  chk_latched_hold: assert property (mode_r == hsmc_pkg::MODE_LATCHED
    |-> !gate_drive_up && fault_out_n_oe && inrush_cnt_r == '0) else $error("latched outputs wrong");
  chk_enable_restart: assert property (mode_r == hsmc_pkg::MODE_LATCHED && en_rise && !abort
    |=> mode_r == hsmc_pkg::MODE_INRUSH && fault_cnt_r == '0) else $error("enable edge did not restart");
  chk_retry_done: assert property ($past(mode_r) == hsmc_pkg::MODE_RETRY && mode_r == hsmc_pkg::MODE_INRUSH
    |-> $past(rty_num_r) == 7'h3f && $past(rty_dir_r)) else $error("retry left early");
  chk_fault_pin: assert property (over_temp || (!switch_enable && current_monitor_over_short)
    |=> fault_out_n_oe && !fault_out_n_o) else $error("fault pin not pulled");
  chk_option_static: assert property (opt_valid_r && $past(opt_valid_r) |-> $stable(opt_r))
    else $error("response option changed");

  cov_regular: cover property ($past(mode_r) == hsmc_pkg::MODE_INRUSH && mode_r == hsmc_pkg::MODE_REGULAR);
  cov_fast_trip: cover property ($rose(gate_strong_pd));
  cov_retry_exit: cover property ($past(mode_r) == hsmc_pkg::MODE_RETRY && mode_r == hsmc_pkg::MODE_INRUSH);
  cov_restart: cover property ($past(mode_r) == hsmc_pkg::MODE_LATCHED && mode_r == hsmc_pkg::MODE_INRUSH);
endmodule // hsmc_top
